// *** src/dsc_defs.vh ***
// constants for the dual switch control block
`ifndef DSC_DEFS_VH
`define DSC_DEFS_VH
// spi frame length in bits
`define DSC_FRAME_BITS      16
`define DSC_FRAME_CNT_W     5
// control word field layout of a received frame
`define DSC_F_MODE0_LO      0
`define DSC_F_MODE1_LO      2
`define DSC_F_SENSE_SEL     4
`define DSC_F_RATIO0        5
`define DSC_F_RATIO1        6
`define DSC_F_DUTY0_LO      8
`define DSC_F_DUTY1_LO      12
// channel control modes
`define DSC_MODE_DIRECT     2'h0
`define DSC_MODE_INT_CLK    2'h1
`define DSC_MODE_EXT_CLK    2'h2
// reset values
`define DSC_RST_MODE        2'h0
`define DSC_RST_DUTY        4'h8
// watchdog: frame must arrive within this time, in us
`define DSC_WD_TIME_US      32'd1000
`define DSC_CLK_MHZ         32'd200
`define DSC_WD_CYCLES       (`DSC_WD_TIME_US * `DSC_CLK_MHZ)
// internal pwm prescaler, last count of a pwm step (256 cycles per step)
`define DSC_INT_PRESC       16'h00ff
// sense settling time after a switch change, ns, rounded up
`define DSC_SETTLE_NS       32'd1000
`define DSC_SETTLE_CYCLES   ((`DSC_SETTLE_NS + 32'd4) / 32'd5)
`endif

// *** src/dsc_top.v ***
// control logic of the dual high side switch
`timescale 1ns/1ps
`include "dsc_defs.vh"

// Function
// - in direct mode each switch follows its direct input level
// - each channel selects external clock, internal clock or direct input
// - internal clock mode switches autonomously from an on-chip pwm
// - external clock mode takes its pwm time base from the clock pin
// - lost spi traffic enters fail-safe; switches follow direct inputs
// - fail-safe drives the open-drain fail-safe flag low
// - fault mode drives the open-drain fault flag low
// - reset input returns configuration and fault registers to defaults
// - after reset sleep is entered only if no direct input is active
// - profile select pins choose bulb or motor over-current profile
// - spi settings select current or temperature sense and the ratio
// - every spi frame is sixteen bits long
// - sense sync output asserts while sense output is settled
module dsc_top #(
	parameter WD_CYCLES = `DSC_WD_CYCLES
) (
	input  wire        core_clk,
	input  wire        resetn,
	input  wire        direct_ctrl_ch0,
	input  wire        direct_ctrl_ch1,
	input  wire        profile_sel_ch0,
	input  wire        profile_sel_ch1,
	input  wire        init_pin_n,
	input  wire        pwm_clock_pin,
	input  wire        spi_select_n,
	input  wire        spi_sclk,
	input  wire        spi_sdi,
	output reg         spi_sdo,
	input  wire [1:0]  fault_event,
	output reg         switch_out_ch0,
	output reg         switch_out_ch1,
	output reg  [1:0]  motor_profile,
	output reg         sense_temp_sel,
	output reg  [1:0]  sense_ratio_hi,
	output reg         sleep_mode,
	output wire        failsafe_flag_n_o,
	output wire        failsafe_flag_n_oe,
	output wire        fault_flag_n_o,
	output wire        fault_flag_n_oe,
	output wire        sense_sync_n_o,
	output wire        sense_sync_n_oe
);
	// two-flop synchronisers for every pin input except resetn; left out of reset so
	// the true pin levels are in place when reset is released
	localparam NSYNC = 11;
	wire [NSYNC-1:0] pin_raw;
	wire [NSYNC-1:0] pin_s;
	assign pin_raw = {fault_event, pwm_clock_pin, spi_sdi, spi_sclk,
		spi_select_n, init_pin_n, profile_sel_ch1, profile_sel_ch0,
		direct_ctrl_ch1, direct_ctrl_ch0};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
			reg meta_q;
			reg stab_q;
			always @(posedge core_clk) begin
				meta_q <= pin_raw[gi];
				stab_q <= meta_q;
			end
			assign pin_s[gi] = stab_q;
		end
	endgenerate
	wire       din0_s  = pin_s[0];
	wire       din1_s  = pin_s[1];
	wire [1:0] prof_s  = pin_s[3:2];
	wire       init_s  = pin_s[4];
	wire       sel_n_s = pin_s[5];
	wire       sclk_s  = pin_s[6];
	wire       sdi_s   = pin_s[7];
	wire       pclk_s  = pin_s[8];
	wire [1:0] flt_s   = pin_s[10:9];

	// combined reset: core reset or init pin held low
	wire rst_all = !resetn || !init_s;

	// spi and pwm clock edge detection on synchronised levels
	reg sclk_q;
	reg pclk_q;
	always @(posedge core_clk) begin
		if (!resetn) begin
			sclk_q <= 1'b0;
			pclk_q <= 1'b0;
		end else begin
			sclk_q <= sclk_s;
			pclk_q <= pclk_s;
		end
	end
	wire sclk_rise = sclk_s && !sclk_q;
	wire sclk_fall = !sclk_s && sclk_q;
	wire pclk_rise = pclk_s && !pclk_q;

	// 16-bit shift register; previous frame shifts out for daisy chains
	reg [15:0]                shift_q;
	reg [`DSC_FRAME_CNT_W-1:0] bits_q;
	reg                       sel_q;
	reg                       frame_ok;
	always @(posedge core_clk) begin
		if (rst_all) begin
			shift_q <= 16'h0000;
			bits_q  <= 5'h00;
			sel_q   <= 1'b0;
			spi_sdo <= 1'b0;
		end else begin
			sel_q <= !sel_n_s;
			if (sel_n_s) begin
				bits_q <= 5'h00;
			end else if (sclk_rise) begin
				shift_q <= {shift_q[14:0], sdi_s};
				bits_q  <= bits_q + 5'h01;
			end
			// msb stands while deselected, ready before the first clock
			if (sel_n_s || sclk_fall) begin
				spi_sdo <= shift_q[15];
			end
		end
	end
	// a frame counts only when the 5-bit clock count reads sixteen at deselect
	always @* begin
		frame_ok = sel_q && sel_n_s &&
			(bits_q == `DSC_FRAME_BITS);
	end

	// configuration registers loaded from a valid frame
	reg [1:0] mode0_q;
	reg [1:0] mode1_q;
	reg [3:0] duty0_q;
	reg [3:0] duty1_q;
	always @(posedge core_clk) begin
		if (rst_all) begin
			mode0_q        <= `DSC_RST_MODE;
			mode1_q        <= `DSC_RST_MODE;
			duty0_q        <= `DSC_RST_DUTY;
			duty1_q        <= `DSC_RST_DUTY;
			sense_temp_sel <= 1'b0;
			sense_ratio_hi <= 2'h0;
		end else if (frame_ok) begin
			mode0_q <= shift_q[`DSC_F_MODE0_LO+1:`DSC_F_MODE0_LO];
			mode1_q <= shift_q[`DSC_F_MODE1_LO+1:`DSC_F_MODE1_LO];
			duty0_q <= shift_q[`DSC_F_DUTY0_LO+3:`DSC_F_DUTY0_LO];
			duty1_q <= shift_q[`DSC_F_DUTY1_LO+3:`DSC_F_DUTY1_LO];
			sense_temp_sel <= shift_q[`DSC_F_SENSE_SEL];
			sense_ratio_hi <= {shift_q[`DSC_F_RATIO1],
				shift_q[`DSC_F_RATIO0]};
		end
	end

	// watchdog: no valid frame for WD_CYCLES means fail-safe
	reg [31:0] wd_q;
	reg        fs_q;
	always @(posedge core_clk) begin
		if (rst_all) begin
			wd_q <= 32'h00000000;
			fs_q <= 1'b0;
		end else if (frame_ok) begin
			wd_q <= 32'h00000000;
			fs_q <= 1'b0;
		end else if (wd_q >= WD_CYCLES - 1) begin
			fs_q <= 1'b1;
		end else begin
			wd_q <= wd_q + 32'h00000001;
		end
	end

	// internal pwm counter free-running from the core clock, external one counting clock pin rises
	reg [15:0] presc_q;
	reg [3:0]  int_cnt_q;
	reg [3:0]  ext_cnt_q;
	always @(posedge core_clk) begin
		if (rst_all) begin
			presc_q   <= 16'h0000;
			int_cnt_q <= 4'h0;
			ext_cnt_q <= 4'h0;
		end else begin
			if (presc_q == `DSC_INT_PRESC) begin
				presc_q   <= 16'h0000;
				int_cnt_q <= int_cnt_q + 4'h1;
			end else begin
				presc_q <= presc_q + 16'h0001;
			end
			if (pclk_rise) begin
				ext_cnt_q <= ext_cnt_q + 4'h1;
			end
		end
	end

	// per-channel switch decision
	reg [1:0] sw_d;
	always @* begin
		sw_d[0] = 1'b0;
		sw_d[1] = 1'b0;
		if (fs_q) begin
			sw_d = {din1_s, din0_s};
		end else begin
			case (mode0_q)
			`DSC_MODE_DIRECT:  sw_d[0] = din0_s;
			`DSC_MODE_INT_CLK: sw_d[0] = int_cnt_q < duty0_q;
			`DSC_MODE_EXT_CLK: sw_d[0] = ext_cnt_q < duty0_q;
			default:           sw_d[0] = 1'b0;
			endcase
			case (mode1_q)
			`DSC_MODE_DIRECT:  sw_d[1] = din1_s;
			`DSC_MODE_INT_CLK: sw_d[1] = int_cnt_q < duty1_q;
			`DSC_MODE_EXT_CLK: sw_d[1] = ext_cnt_q < duty1_q;
			default:           sw_d[1] = 1'b0;
			endcase
		end
	end

	// fault latch: reset wins over set, otherwise hold until reset
	reg [1:0] fault_q;
	reg       sleep_arm_q;
	always @(posedge core_clk) begin
		if (rst_all) begin
			fault_q     <= 2'h0;
			sleep_arm_q <= 1'b1;
		end else begin
			fault_q     <= fault_q | flt_s;
			sleep_arm_q <= 1'b0;
		end
	end

	// outputs, sleep and sense settling
	reg [7:0] settle_q;
	always @(posedge core_clk) begin
		if (rst_all) begin
			switch_out_ch0 <= 1'b0;
			switch_out_ch1 <= 1'b0;
			motor_profile  <= 2'h0;
			sleep_mode     <= 1'b0;
			settle_q       <= 8'h00;
		end else begin
			switch_out_ch0 <= sw_d[0] && !fault_q[0];
			switch_out_ch1 <= sw_d[1] && !fault_q[1];
			motor_profile  <= prof_s;
			if (sleep_arm_q) begin
				sleep_mode <= !(din0_s || din1_s);
			end else if (din0_s || din1_s || frame_ok) begin
				sleep_mode <= 1'b0;
			end
			if ((sw_d[0] != switch_out_ch0) ||
				(sw_d[1] != switch_out_ch1)) begin
				settle_q <= 8'h00;
			end else if (settle_q != `DSC_SETTLE_CYCLES) begin
				settle_q <= settle_q + 8'h01;
			end
		end
	end

	// open-drain flags: enable low means the pin is pulled low
	assign failsafe_flag_n_o  = 1'b0;
	assign failsafe_flag_n_oe = !fs_q;
	assign fault_flag_n_o     = 1'b0;
	assign fault_flag_n_oe    = !(|fault_q);
	assign sense_sync_n_o     = 1'b0;
	assign sense_sync_n_oe    =
		!(settle_q == `DSC_SETTLE_CYCLES);
endmodule

// *** tb/dsc_sva.sv ***
// assertion checker of the dual switch control block
`timescale 1ns/1ps
module dsc_sva #(
	parameter WD_CYCLES = 200000
) (
	input wire       core_clk,
	input wire       resetn,
	input wire       init_pin_n,
	input wire       direct_ctrl_ch0,
	input wire       direct_ctrl_ch1,
	input wire       profile_sel_ch0,
	input wire       spi_select_n,
	input wire [1:0] fault_event,
	input wire       switch_out_ch0,
	input wire [1:0] motor_profile,
	input wire       sleep_mode,
	input wire       failsafe_flag_n_o,
	input wire       failsafe_flag_n_oe,
	input wire       fault_flag_n_o,
	input wire       fault_flag_n_oe,
	input wire       sense_sync_n_o,
	input wire       sense_sync_n_oe
);
	reg  [31:0] idle_q;
	wire [31:0] idle_d;
	// cycles since reset or select activity, saturating past the watchdog
	assign idle_d = (idle_q < WD_CYCLES + 16) ? idle_q + 32'h1 : idle_q;
	always @(posedge core_clk) begin
		idle_q <= (!resetn || !init_pin_n || !spi_select_n) ? 32'h0 : idle_d;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// flag checks, open-drain data low, reset, sleep, fault and profile behaviour
	AST_OD_LOW: assert property (
		!failsafe_flag_n_o && !fault_flag_n_o)
		else $error("open-drain data not low");
	AST_RST: assert property (disable iff (1'b0) !resetn |=>
		failsafe_flag_n_oe && fault_flag_n_oe && !switch_out_ch0)
		else $error("reset state wrong");
	AST_FLT_SET: assert property (
		fault_event[0] |-> ##[1:8] !fault_flag_n_oe)
		else $error("fault flag not asserted");
	AST_FLT_OFF: assert property (fault_event[0] |-> ##[1:8]
		!switch_out_ch0 [*4]) else $error("faulted switch not off");
	AST_FLT_HOLD: assert property (
		!fault_flag_n_oe && init_pin_n |=> !fault_flag_n_oe)
		else $error("fault flag dropped");
	AST_SLEEP: assert property (
		$rose(resetn) && $stable(direct_ctrl_ch0) &&
		$stable(direct_ctrl_ch1) |=>
		sleep_mode == !(direct_ctrl_ch0 || direct_ctrl_ch1))
		else $error("sleep wrong");
	AST_FS_LATE: assert property (idle_q == WD_CYCLES + 16 |->
		!failsafe_flag_n_oe) else $error("no failsafe after silence");
	AST_SYNC: assert property (!$stable(switch_out_ch0) |-> ##2
		sense_sync_n_oe [*8]) else $error("sync low while settling");
	AST_PROF: assert property (
		(init_pin_n && $stable(profile_sel_ch0)) [*8] |->
		motor_profile[0] == profile_sel_ch0)
		else $error("profile wrong");
	// main scenarios seen
	cover property (fault_event[0]);
	cover property ($fell(failsafe_flag_n_oe));
	cover property ($rose(switch_out_ch0));
endmodule
bind dsc_top dsc_sva #(.WD_CYCLES(WD_CYCLES)) u_sva (
	.core_clk          (core_clk),
	.resetn            (resetn),
	.init_pin_n        (init_pin_n),
	.direct_ctrl_ch0   (direct_ctrl_ch0),
	.direct_ctrl_ch1   (direct_ctrl_ch1),
	.profile_sel_ch0   (profile_sel_ch0),
	.spi_select_n      (spi_select_n),
	.fault_event       (fault_event),
	.switch_out_ch0    (switch_out_ch0),
	.motor_profile     (motor_profile),
	.sleep_mode        (sleep_mode),
	.failsafe_flag_n_o (failsafe_flag_n_o),
	.failsafe_flag_n_oe(failsafe_flag_n_oe),
	.fault_flag_n_o    (fault_flag_n_o),
	.fault_flag_n_oe   (fault_flag_n_oe),
	.sense_sync_n_o    (sense_sync_n_o),
	.sense_sync_n_oe   (sense_sync_n_oe)
);

// *** tb/dsc_host.sv ***
// host model driving spi frames into the switch control block
`timescale 1ns/1ps
module dsc_host (
	input  wire        core_clk,
	input  wire        spi_sdo,
	output reg         spi_select_n,
	output reg         spi_sclk,
	output reg         spi_sdi,
	output reg  [15:0] rx
);
	integer i;
	// idle levels follow the pin pulls: select up, clock and data down
	initial begin
		spi_select_n = 1'b1;
		spi_sclk = 1'b0;
		spi_sdi = 1'b0;
		rx = 16'h0000;
	end
	// one frame msb first, 26 cycles a bit keeps sclk below 8 mhz
	task send(input [15:0] frm, input integer nb);
		begin
			@(posedge core_clk);
			#1 spi_select_n = 1'b0;
			for (i = nb - 1; i >= 0; i = i - 1) begin
				spi_sdi = frm[i];
				repeat (13) @(posedge core_clk);
				#1 spi_sclk = 1'b1;
				rx = {rx[14:0], spi_sdo};
				repeat (13) @(posedge core_clk);
				#1 spi_sclk = 1'b0;
			end
			repeat (13) @(posedge core_clk);
			#1 spi_select_n = 1'b1;
			spi_sdi = 1'b0;
			repeat (12) @(posedge core_clk);
			#1;
		end
	endtask
endmodule

// *** tb/tb_top.sv ***
// self-checking testbench of the dual switch control block
`timescale 1ns/1ps
module tb_top;
	localparam WD = 20000;
	reg        core_clk, resetn, direct_ctrl_ch0, direct_ctrl_ch1;
	reg        profile_sel_ch0, profile_sel_ch1, init_pin_n, pwm_clock_pin;
	reg  [1:0] fault_event;
	wire       spi_select_n, spi_sclk, spi_sdi, sw0, sw1, temp, sleep, fs, flt;
	wire       sdo, sync_n;
	wire [1:0] motor_profile, ratio;
	wire [15:0] chain_rx;
	integer    fails = 0, compares = 0, i, n;
	reg        p;
	dsc_host host (.core_clk(core_clk), .spi_sdo(sdo), .rx(chain_rx),
		.spi_select_n(spi_select_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi));
	dsc_top #(.WD_CYCLES(WD)) dut (.core_clk(core_clk), .resetn(resetn),
		.direct_ctrl_ch0(direct_ctrl_ch0), .direct_ctrl_ch1(direct_ctrl_ch1),
		.profile_sel_ch0(profile_sel_ch0), .profile_sel_ch1(profile_sel_ch1),
		.init_pin_n(init_pin_n), .pwm_clock_pin(pwm_clock_pin),
		.spi_select_n(spi_select_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
		.spi_sdo(sdo), .fault_event(fault_event), .switch_out_ch0(sw0),
		.switch_out_ch1(sw1), .motor_profile(motor_profile),
		.sense_temp_sel(temp), .sense_ratio_hi(ratio), .sleep_mode(sleep),
		.failsafe_flag_n_o(), .failsafe_flag_n_oe(fs), .fault_flag_n_o(),
		.fault_flag_n_oe(flt), .sense_sync_n_o(), .sense_sync_n_oe(sync_n));
	// 200 mhz clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = !core_clk;
	end
	// wait edges, then step just past the edge
	task step(input integer c);
		begin
			repeat (c) @(posedge core_clk);
			#1;
		end
	endtask
	task chk(input string nm, input [15:0] e, input [15:0] g);
		begin
			compares = compares + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("CHECK FAILED %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task do_reset(input d0);
		begin
			resetn = 1'b0;
			direct_ctrl_ch0 = d0;
			step(6);
			resetn = 1'b1;
			step(1);
			chk("sleep", {1'b0, !d0}, {1'b0, sleep});
		end
	endtask
	// count switch changes, optionally toggling the pwm clock pin
	task run(input ch, input tg, input integer c);
		begin
			n = 0;
			p = ch ? sw1 : sw0;
			for (i = 0; i < c; i = i + 1) begin
				step(1);
				if (tg && i % 4 == 0)
					pwm_clock_pin = !pwm_clock_pin;
				if ((ch ? sw1 : sw0) !== p)
					n = n + 1;
				p = ch ? sw1 : sw0;
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("compares %0d fails %0d", compares, fails);
			if (fails == 0 && compares > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	initial begin
		#450000;
		fails = fails + 1;
		tally_and_finish;
	end
	initial begin
		{direct_ctrl_ch1, profile_sel_ch1, pwm_clock_pin} = 3'h0;
		{profile_sel_ch0, init_pin_n} = 2'h3;
		fault_event = 2'h0;
		do_reset(1'b1);
		do_reset(1'b0);
		chk("flags", 2'h3, {fs, flt});
		step(10);
		chk("profile", 2'h1, motor_profile);
		{profile_sel_ch0, profile_sel_ch1} = 2'h1;
		step(10);
		chk("profile", 2'h2, motor_profile);
		$display("test reset done");
		direct_ctrl_ch0 = 1'b1;
		step(10);
		chk("direct", 2'h1, {sw1, sw0});
		{direct_ctrl_ch0, direct_ctrl_ch1} = 2'h1;
		step(10);
		chk("direct", 2'h2, {sw1, sw0});
		direct_ctrl_ch1 = 1'b0;
		host.send(16'h8834, 16);
		chk("temp", 2'h1, {1'b0, temp});
		chk("ratio", 2'h1, ratio);
		run(1'b1, 1'b0, 9000);
		chk("int pwm", 2'h1, {1'b0, n > 1});
		host.send(16'h0000, 15);
		chk("short frame", 2'h1, {1'b0, temp});
		host.send(16'h8836, 16);
		run(1'b0, 1'b1, 2000);
		chk("ext pwm", 2'h1, {1'b0, n > 1});
		step(20);
		run(1'b0, 1'b0, 2000);
		chk("ext idle", 2'h0, {1'b0, n != 0});
		$display("test modes done");
		fault_event = 2'h1;
		step(2);
		fault_event = 2'h0;
		step(110);
		chk("fault", 2'h0, {flt, sw0});
		init_pin_n = 1'b0;
		step(6);
		init_pin_n = 1'b1;
		step(10);
		chk("init", 2'h2, {flt, temp});
		$display("test fault done");
		host.send(16'h8801, 16);
		direct_ctrl_ch0 = 1'b1;
		step(WD + 50);
		chk("failsafe", 2'h0, {1'b0, fs});
		run(1'b0, 1'b0, 4200);
		chk("fs follow", 2'h1, {n != 0, sw0});
		chk("sync", 2'h0, {1'b0, sync_n});
		host.send(16'h8801, 16);
		chk("fs clear", 2'h1, {1'b0, fs});
		chk("chain", 16'h8801, chain_rx);
		$display("test failsafe done");
		tally_and_finish;
	end
endmodule
